/* File: logic/scc_map.svh */
// register map, field positions and counts of the spi control block
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH

// register addresses
`define SCC_ADDR_CTRL   8'hF3
`define SCC_ADDR_STAT   8'hF4
`define SCC_ADDR_DATA   8'hF5
`define SCC_ADDR_MASK   8'hF6

// reset values
`define SCC_CTRL_RESET  8'h00
`define SCC_BYTE_ZERO   8'h00

// status register bit positions
`define SCC_STAT_DONE   7
`define SCC_STAT_WCOL   6
`define SCC_STAT_FAULT  4
`define SCC_STAT_FDD    3

// edge counting: sixteen shift-clock edges per byte
`define SCC_EDGE_FIRST  4'h0
`define SCC_EDGE_LAST   4'hF

// half period of the divide-by-16 shift clock, in peripheral clocks
`define SCC_HALF_BASE   7'h08
`define SCC_HALF_ZERO   7'h00
`define SCC_HALF_ONE    7'h01

`endif

/* File: logic/scc_pkg.sv */
// types shared by the spi control block
package scc_pkg;

   // control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       select_output_enable;
      logic       port_enable_bit;
      logic       low_bit_first_enable;
      logic       master_role_select;
      logic       clock_idle_level;
      logic       sample_edge_select;
      logic [1:0] rate_select;
   } scc_ctrl_t;

   // transfer engine states
   typedef enum logic {
      SCC_IDLE,
      SCC_SHIFT
   } scc_state_t;

   // one driven pin: level and active-low output enable
   typedef struct packed {
      logic level;
      logic oe_n;
   } scc_pin_t;

endpackage

/* File: logic/scc_rate_div.sv */
// shift-clock half-period divider of the spi control block
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"

module scc_rate_div
   import scc_pkg::*;
(
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   // control
   input  wire logic       i_run,
   input  wire logic [1:0] i_rate,
   // half-period tick
   output logic            o_tick
);

   // ****************************************
   // half-period counter
   // ****************************************
   logic [6:0] cnt_r;   // counts peripheral clocks
   logic [6:0] limit;   // last count of a half period

   // 8, 16, 32 or 64 clocks per half: divide by 16..128
   assign limit = (`SCC_HALF_BASE << i_rate) - `SCC_HALF_ONE;

   // counter restarts while stopped, so every byte begins aligned
   always_ff @(posedge i_clock) begin
      if (i_rst || !i_run) begin
         cnt_r <= `SCC_HALF_ZERO;
      end else if (cnt_r == limit) begin
         cnt_r <= `SCC_HALF_ZERO;
      end else begin
         cnt_r <= cnt_r + `SCC_HALF_ONE;
      end
   end

   // one pulse per half period
   assign o_tick = i_run && (cnt_r == limit);

endmodule // scc_rate_div

`default_nettype wire

/* File: logic/scc_select_ctl.sv */
// select pin role decoder of the spi control block
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"

module scc_select_ctl
   import scc_pkg::*;
(
   // clock and reset
   input  wire logic      i_clock,
   input  wire logic      i_rst,
   // configuration
   input  wire scc_ctrl_t i_ctrl,
   input  wire logic      i_fault_detect_disable,
   input  wire logic      i_busy,
   // select pin
   input  wire logic      i_ss_n,
   output scc_pin_t       o_ss,
   // decoded roles
   output logic           o_fault,
   output logic           o_slave_sel
);

   // ****************************************
   // role decode
   // ****************************************
   logic master_on;   // port enabled as master
   logic auto_out;    // automatic select output

   assign master_on = i_ctrl.port_enable_bit &&
                      i_ctrl.master_role_select;

   // output enable counts only as master with detect off
   assign auto_out = master_on && i_fault_detect_disable &&
                     i_ctrl.select_output_enable;

   // low select while detect is on flags a fault
   assign o_fault = master_on && !i_fault_detect_disable && !i_ss_n;

   // slave always listens to the select pin
   assign o_slave_sel = i_ctrl.port_enable_bit &&
                        !i_ctrl.master_role_select && !i_ss_n;

   // ****************************************
   // pin drive
   // ****************************************
   // registered so the pin never glitches between decodes
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_ss.level <= 1'b1;
         o_ss.oe_n  <= 1'b1;
      end else if (auto_out) begin
         // low during each byte, high when idle
         o_ss.level <= !i_busy;
         o_ss.oe_n  <= 1'b0;
      end else begin
         // released: gpio, fault input or slave input
         o_ss.level <= 1'b1;
         o_ss.oe_n  <= 1'b1;
      end
   end

endmodule // scc_select_ctl

`default_nettype wire

/* File: logic/scc_spi_control_config.sv */
// spi control, select-pin and byte transfer logic
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"

module scc_spi_control_config
   import scc_pkg::*;
(
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   // register port
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic [7:0]      o_rdata,
   // interrupt
   output logic            o_irq,
   // shift clock pin
   input  wire logic       i_sclk,
   output logic            o_sclk,
   output logic            o_sclk_oe_n,
   // master-out pin
   input  wire logic       i_mosi,
   output logic            o_mosi,
   output logic            o_mosi_oe_n,
   // master-in pin
   input  wire logic       i_miso,
   output logic            o_miso,
   output logic            o_miso_oe_n,
   // select pin
   input  wire logic       i_ss_n,
   output logic            o_ss_n,
   output logic            o_ss_oe_n
);

   // ****************************************
   // declarations
   // ****************************************
   scc_ctrl_t  ctrl_r;        // control register
   scc_ctrl_t  xfer_r;        // settings of the byte in flight
   logic       fdd_r;         // fault detect disable
   logic       done_r;        // transfer complete flag
   logic       wcol_r;        // write collision flag
   logic       fault_r;       // role fault flag
   logic [7:0] mask_r;        // interrupt mask
   logic [7:0] rbuf_r;        // received byte buffer
   logic [7:0] rdata_r;       // read data register
   scc_state_t state_r;       // engine state
   logic [7:0] tx_r;          // transmit shifter
   logic [7:0] rx_r;          // receive shifter
   logic [7:0] rx_nxt;        // receive shifter next value
   logic [3:0] edge_r;        // edge index within the byte
   logic       sclk_r;        // master clock level
   logic       sclk_prev_r;   // last sampled slave clock
   logic [7:0] stat;          // status as read
   scc_pin_t   ss_pin;        // select pin drive
   logic       fault_now;     // fault seen on select pin
   logic       slave_sel;     // slave selected
   logic       tick;          // master half-period tick
   logic       clk_edge;      // shift-clock edge this cycle
   logic       leading;       // edge is the first of a bit
   logic       sample_now;    // capture an input bit
   logic       shift_now;     // present next output bit
   logic       last_edge;     // final edge of the byte
   logic       in_bit;        // incoming serial bit
   logic       out_bit;       // outgoing serial bit
   logic       wr_ctrl;       // control write
   logic       wr_stat;       // status write
   logic       wr_data;       // data write
   logic       wr_mask;       // mask write
   logic       start_m;       // master byte start
   logic       start_s;       // slave byte start
   logic       wr_ok;         // data write accepted
   logic       abort;         // byte given up

   // ****************************************
   // address decode
   // ****************************************
   assign wr_ctrl = i_wr && (i_addr == `SCC_ADDR_CTRL);
   assign wr_stat = i_wr && (i_addr == `SCC_ADDR_STAT);
   assign wr_data = i_wr && (i_addr == `SCC_ADDR_DATA);
   assign wr_mask = i_wr && (i_addr == `SCC_ADDR_MASK);

   // ****************************************
   // control register
   // ****************************************
   // every field cleared at reset: slave, msb first, /16
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         ctrl_r <= scc_ctrl_t'(`SCC_CTRL_RESET);
      end else if (wr_ctrl) begin
         // fields steer enable, order, role, clock
         ctrl_r <= scc_ctrl_t'(i_wdata);
      end
   end

   // fault detect disable lives in the status register
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         fdd_r <= 1'b0;
      end else if (wr_stat) begin
         fdd_r <= i_wdata[`SCC_STAT_FDD];
      end
   end

   // interrupt mask, same layout as status
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         mask_r <= `SCC_BYTE_ZERO;
      end else if (wr_mask) begin
         mask_r <= i_wdata;
      end
   end

   // ****************************************
   // select pin
   // ****************************************
   scc_select_ctl u_select (
      .i_clock                (i_clock),
      .i_rst                  (i_rst),
      .i_ctrl                 (ctrl_r),
      .i_fault_detect_disable (fdd_r),
      .i_busy                 (state_r == SCC_SHIFT),
      .i_ss_n                 (i_ss_n),
      .o_ss                   (ss_pin),
      .o_fault                (fault_now),
      .o_slave_sel            (slave_sel)
   );

   assign o_ss_n    = ss_pin.level;
   assign o_ss_oe_n = ss_pin.oe_n;

   // ****************************************
   // shift clock timing
   // ****************************************
   // divider runs only while a master byte is in flight
   scc_rate_div u_rate (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_run   ((state_r == SCC_SHIFT) && xfer_r.master_role_select),
      .i_rate  (xfer_r.rate_select),
      .o_tick  (tick)
   );

   // master edges come from the divider, slave edges from the pin
   always_comb begin
      if (xfer_r.master_role_select) begin
         clk_edge = tick;
      end else begin
         clk_edge = (state_r == SCC_SHIFT) && slave_sel &&
                    (i_sclk != sclk_prev_r);
      end
   end

   // even edges lead a bit, odd edges trail it
   assign leading   = !edge_r[0];
   // second-edge sampling swaps sample and shift edges
   assign sample_now = clk_edge && (leading ^ xfer_r.sample_edge_select);
   assign last_edge  = clk_edge && (edge_r == `SCC_EDGE_LAST);
   // the first bit is already on the line, so in second-edge format
   // the first shift edge is skipped, and nothing after the last
   assign shift_now = clk_edge && !sample_now && !last_edge &&
                      !(xfer_r.sample_edge_select &&
                        (edge_r == `SCC_EDGE_FIRST));

   // ****************************************
   // bit order
   // ****************************************
   // lsb or msb leaves and enters first
   assign out_bit = xfer_r.low_bit_first_enable ? tx_r[0] : tx_r[7];
   assign in_bit  = xfer_r.master_role_select ? i_miso : i_mosi;

   always_comb begin
      rx_nxt = rx_r;
      if (sample_now) begin
         if (xfer_r.low_bit_first_enable) begin
            rx_nxt = {in_bit, rx_r[7:1]};
         end else begin
            rx_nxt = {rx_r[6:0], in_bit};
         end
      end
   end

   // ****************************************
   // start, collision and abort
   // ****************************************
   // a write is refused while busy or before the flag is cleared
   assign wr_ok = wr_data && (state_r == SCC_IDLE) && !done_r;

   // master data write starts a full-duplex byte
   assign start_m = wr_ok && ctrl_r.port_enable_bit &&
                    ctrl_r.master_role_select;

   // slave starts whenever it is idle with its select low
   assign start_s = (state_r == SCC_IDLE) && slave_sel;

   // disable, a role fault or a released select end the byte
   always_comb begin
      if (!ctrl_r.port_enable_bit) begin
         abort = 1'b1;
      end else if (xfer_r.master_role_select) begin
         abort = fault_now;
      end else begin
         abort = !slave_sel;
      end
   end

   // ****************************************
   // transfer engine
   // ****************************************
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_r <= SCC_IDLE;
         edge_r  <= `SCC_EDGE_FIRST;
         xfer_r  <= scc_ctrl_t'(`SCC_CTRL_RESET);
      end else begin
         case (state_r)
            SCC_IDLE: begin
               edge_r <= `SCC_EDGE_FIRST;
               if (start_m || start_s) begin
                  // settings frozen for the whole byte
                  xfer_r  <= ctrl_r;
                  state_r <= SCC_SHIFT;
               end
            end
            SCC_SHIFT: begin
               if (abort || last_edge) begin
                  state_r <= SCC_IDLE;
               end else if (clk_edge) begin
                  edge_r <= edge_r + 4'h1;
               end
            end
            default: begin
               state_r <= SCC_IDLE;
            end
         endcase
      end
   end

   // transmit shifter: loaded by software, moved on shift edges
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         tx_r <= `SCC_BYTE_ZERO;
      end else if (wr_ok) begin
         tx_r <= i_wdata;
      end else if (shift_now) begin
         if (xfer_r.low_bit_first_enable) begin
            tx_r <= {1'b0, tx_r[7:1]};
         end else begin
            tx_r <= {tx_r[6:0], 1'b0};
         end
      end
   end

   // receive shifter and its buffer
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rx_r   <= `SCC_BYTE_ZERO;
         rbuf_r <= `SCC_BYTE_ZERO;
      end else begin
         rx_r <= rx_nxt;
         if (last_edge && !abort) begin
            rbuf_r <= rx_nxt;
         end
      end
   end

   // master clock: toggles per half period, rests at idle level
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         sclk_r <= 1'b0;
      end else if (state_r == SCC_IDLE) begin
         sclk_r <= ctrl_r.clock_idle_level;
      end else if (tick) begin
         sclk_r <= !sclk_r;
      end
   end

   // slave clock history, reset to idle level at each start
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         sclk_prev_r <= 1'b0;
      end else if (state_r == SCC_IDLE) begin
         sclk_prev_r <= ctrl_r.clock_idle_level;
      end else begin
         sclk_prev_r <= i_sclk;
      end
   end

   // ****************************************
   // status flags
   // ****************************************
   // a set in the same cycle as a clear wins
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         done_r  <= 1'b0;
         wcol_r  <= 1'b0;
         fault_r <= 1'b0;
      end else begin
         done_r  <= (last_edge && !abort) ||
                    (done_r && !(wr_stat && i_wdata[`SCC_STAT_DONE]));
         wcol_r  <= (wr_data && !wr_ok) ||
                    (wcol_r && !(wr_stat && i_wdata[`SCC_STAT_WCOL]));
         // fault flagged the cycle the pin is seen low
         fault_r <= fault_now ||
                    (fault_r && !(wr_stat && i_wdata[`SCC_STAT_FAULT]));
      end
   end

   always_comb begin
      stat                 = `SCC_BYTE_ZERO;
      stat[`SCC_STAT_DONE]  = done_r;
      stat[`SCC_STAT_WCOL]  = wcol_r;
      stat[`SCC_STAT_FAULT] = fault_r;
      stat[`SCC_STAT_FDD]   = fdd_r;
   end

   // level interrupt; the detect-disable bit is not an event
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= done_r && mask_r[`SCC_STAT_DONE] ||
                  wcol_r && mask_r[`SCC_STAT_WCOL] ||
                  fault_r && mask_r[`SCC_STAT_FAULT];
      end
   end

   // ****************************************
   // read port
   // ****************************************
   // data valid only in the cycle after the strobe
   always_ff @(posedge i_clock) begin
      if (i_rst || !i_rd) begin
         rdata_r <= `SCC_BYTE_ZERO;
      end else begin
         case (i_addr)
            `SCC_ADDR_CTRL: rdata_r <= ctrl_r;
            `SCC_ADDR_STAT: rdata_r <= stat;
            `SCC_ADDR_DATA: rdata_r <= rbuf_r;
            `SCC_ADDR_MASK: rdata_r <= mask_r;
            default:        rdata_r <= `SCC_BYTE_ZERO;
         endcase
      end
   end

   assign o_rdata = rdata_r;

   // ****************************************
   // pin drive
   // ****************************************
   // master drives clock and data out; slave drives only
   // its data out, and only while selected
   assign o_sclk      = sclk_r;
   assign o_sclk_oe_n = !(ctrl_r.port_enable_bit &&
                          ctrl_r.master_role_select);
   assign o_mosi      = out_bit;
   assign o_mosi_oe_n = o_sclk_oe_n;
   assign o_miso      = out_bit;
   assign o_miso_oe_n = !slave_sel;

endmodule // scc_spi_control_config

`default_nettype wire

/* File: tb/scc_checker.sv */
// assertion checker for the spi control block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"

module scc_checker (
   // clock, reset and register port
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       o_irq,
   // pins
   input  wire logic       o_sclk,
   input  wire logic       o_sclk_oe_n,
   input  wire logic       o_mosi_oe_n,
   input  wire logic       o_miso_oe_n,
   input  wire logic       i_ss_n,
   input  wire logic       o_ss_n,
   input  wire logic       o_ss_oe_n
);
   // ****************************************
   // shadow of the settings, rebuilt from bus writes
   // ****************************************
   logic [7:0] ctrl_m;  // control register copy
   logic [7:0] mask_m;  // interrupt mask copy
   logic       fdd_m;   // fault detect disable copy
   logic [7:0] gap;     // clocks since the last shift-clock change
   logic [4:0] togs;    // shift-clock changes in this frame
   logic [1:0] rate_l;  // rate held at frame start
   logic [10:0] low_cnt; // clocks select low
   wire        auto_w = ctrl_m[7] & ctrl_m[6] & ctrl_m[4] & fdd_m;

   // copies update on the same edge as the real registers
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         ctrl_m <= 8'h00;
         mask_m <= 8'h00;
         fdd_m  <= 1'b0;
      end else if (i_wr) begin
         if (i_addr == `SCC_ADDR_CTRL) ctrl_m <= i_wdata;
         if (i_addr == `SCC_ADDR_MASK) mask_m <= i_wdata;
         if (i_addr == `SCC_ADDR_STAT) fdd_m <= i_wdata[3];
      end
   end

   // frame counters; rate latched so mid-byte writes cannot move it
   always_ff @(posedge i_clock) begin
      if (i_rst || o_ss_n) begin
         low_cnt <= 11'h000;
         togs   <= 5'h00;
         gap    <= 8'h00;
         rate_l <= ctrl_m[1:0];
      end else begin
         low_cnt <= low_cnt + 11'h001;
         togs <= togs + {4'h0, $changed(o_sclk)};
         gap  <= $changed(o_sclk) ? 8'h01 : gap + 8'h01;
      end
   end

   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   sequence s_auto_end;
      $rose(o_ss_n) ##0 $past(o_ss_oe_n) == 1'b0;
   endsequence

   a_rst_state: assert property (
      $past(i_rst) |-> o_sclk_oe_n && o_mosi_oe_n && o_ss_oe_n && o_ss_n
         && !o_sclk && !o_irq) else $error("pins not idle after reset");
   a_clk_drive: assert property (
      o_sclk_oe_n == !(ctrl_m[6] && ctrl_m[4]) && o_mosi_oe_n == o_sclk_oe_n)
      else $error("clock or data drive wrong for role");
   a_miso_drive: assert property (
      o_miso_oe_n == !(ctrl_m[6] && !ctrl_m[4] && !i_ss_n))
      else $error("slave output drive wrong");
   a_sel_drive: assert property (
      $past(auto_w) && auto_w |-> !o_ss_oe_n) else $error("select not driven");
   a_sel_gpio: assert property (
      $past(auto_w) == 1'b0 && !auto_w |-> o_ss_oe_n)
      else $error("select driven outside auto mode");
   a_fault_input: assert property (
      ctrl_m[4] && !fdd_m && $past(fdd_m) == 1'b0 |-> o_ss_oe_n)
      else $error("fault input driven");
   a_slave_input: assert property (
      !ctrl_m[4] && $past(ctrl_m[4]) == 1'b0 |-> o_ss_oe_n)
      else $error("slave select driven");
   a_clk_idle: assert property (
      o_ss_n && $past(o_ss_n) && !o_ss_oe_n && $stable(ctrl_m[3])
         |-> o_sclk == ctrl_m[3]) else $error("idle clock level wrong");
   a_rate_gap: assert property (
      $changed(o_sclk) && !o_ss_n && togs != 5'h00
         |-> gap == (8'h08 << rate_l)) else $error("clock half period wrong");
   a_frame_end: assert property (
      low_cnt <= 11'd1100 && (!$rose(o_ss_n) || low_cnt >= 11'd120))
      else $error("select not released after byte");
   a_frame_bits: assert property (
      s_auto_end |-> togs == 5'h10) else $error("clock edge count wrong");
   a_fault_irq: assert property (
      ctrl_m[6] && ctrl_m[4] && !fdd_m && !i_ss_n && mask_m[4]
         |-> ##[1:3] o_irq) else $error("fault raised no interrupt");
endmodule // scc_checker

bind scc_spi_control_config scc_checker u_chk (.i_clock, .i_rst, .i_addr,
   .i_wdata, .i_wr, .o_irq, .o_sclk, .o_sclk_oe_n, .o_mosi_oe_n,
   .o_miso_oe_n, .i_ss_n, .o_ss_n, .o_ss_oe_n);
`default_nettype wire

/* File: tb/scc_slave_model.sv */
// behavioural external spi slave exchanging one byte per frame
`timescale 1ns/1ps
`default_nettype none

module scc_slave_model (
   // link pins
   input  wire logic       i_sclk,
   input  wire logic       i_mosi,
   input  wire logic       i_ss_n,
   output logic            o_miso,
   // frame format, which must match the master
   input  wire logic       i_idle_level,
   input  wire logic       i_second_edge,
   input  wire logic       i_low_first,
   input  wire logic [7:0] i_tx,
   output logic [7:0]      o_rx
);
   int   n_in  = 0;    // bits taken
   int   n_out = 0;    // bits presented
   logic cur   = 1'b0; // bit on the line
   function automatic int pos(input int n);
      return i_low_first ? n : 7 - n;
   endfunction
   // a released line shows the inverse so a stale bit never matches
   assign o_miso = i_ss_n ? ~cur : cur;
   // first-edge format puts its first bit out at select
   always @(negedge i_ss_n) begin
      n_in = 0;
      n_out = 0;
      if (!i_second_edge) begin
         cur = i_tx[pos(0)];
         n_out = 1;
      end
   end
   // leading edge samples in first-edge format, trailing otherwise
   always @(i_sclk) if (!i_ss_n) begin
      if ((i_sclk != i_idle_level) ^ i_second_edge) begin
         o_rx[pos(n_in)] = i_mosi;
         n_in++;
      end else if (n_out < 8) begin
         cur = i_tx[pos(n_out)];
         n_out++;
      end
   end
endmodule // scc_slave_model
`default_nettype wire

/* File: tb/scc_spi_control_config_bench.sv */
// self-checking bench of the spi control block
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"

module scc_spi_control_config_bench;
   // ****************************************
   // signals
   // ****************************************
   logic       clk, rst, wr, rd, ext_ss_n, pol, pha, lsb;
   logic [7:0] addr, wdata, rdata, s_tx, s_rx, got;
   logic       irq, sclk, sclk_oe_n, mosi, mosi_oe_n, miso, miso_oe_n;
   logic       ss_n, ss_oe_n, m_miso;
   int         err_total, n_checks;
   // pins resolved from the dut's output enables
   wire logic  sclk_w = sclk_oe_n ? pol : sclk;
   wire logic  mosi_w = mosi_oe_n ? ~mosi : mosi;
   wire logic  miso_w = miso_oe_n ? m_miso : miso;
   wire logic  ss_w   = ss_oe_n ? ext_ss_n : ss_n;
   // rows: control, byte sent, byte the far side answers
   logic [23:0] rows [4] = '{24'hD0A53C, 24'hF5817E, 24'hDA5AC3, 24'hFF0FE1};

   scc_spi_control_config dut (.i_clock(clk), .i_rst(rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
      .i_sclk(sclk_w), .o_sclk(sclk), .o_sclk_oe_n(sclk_oe_n),
      .i_mosi(mosi_w), .o_mosi(mosi), .o_mosi_oe_n(mosi_oe_n),
      .i_miso(miso_w), .o_miso(miso), .o_miso_oe_n(miso_oe_n),
      .i_ss_n(ss_w), .o_ss_n(ss_n), .o_ss_oe_n(ss_oe_n));
   scc_slave_model far (.i_sclk(sclk_w), .i_mosi(mosi_w), .i_ss_n(ss_w),
      .o_miso(m_miso), .i_idle_level(pol), .i_second_edge(pha),
      .i_low_first(lsb), .i_tx(s_tx), .o_rx(s_rx));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic get(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // bounded wait; a hang goes straight to the report
   task automatic wait_irq(input logic lvl);
      int k = 0;
      while (irq !== lvl && k < 3000) begin
         @(posedge clk);
         k++;
      end
      if (k == 3000) begin
         $display("BAD irq expected %h seen %h", lvl, irq);
         err_total++;
         conclude();
      end
   endtask
   // one master byte; mid adds a refused write and new settings in flight
   task automatic xfer(input logic [7:0] c, t, s, input logic mid);
      pol <= c[3];
      pha <= c[2];
      lsb <= c[5];
      s_tx <= s;
      put(`SCC_ADDR_CTRL, c);
      get(`SCC_ADDR_CTRL, got);
      chk("control", c, got);
      put(`SCC_ADDR_DATA, t);
      if (mid) begin
         put(`SCC_ADDR_DATA, 8'h11);
         put(`SCC_ADDR_CTRL, c ^ 8'h23);
      end
      wait_irq(1'b1);
      chk("far byte", t, s_rx);
      get(`SCC_ADDR_DATA, got);
      chk("receive byte", s, got);
      get(`SCC_ADDR_STAT, got);
      chk("status", {1'b1, mid, 6'h08}, got);
      put(`SCC_ADDR_STAT, 8'hC8);
      wait_irq(1'b0);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {rst, wr, rd, ext_ss_n, pol, pha, lsb} = 7'h48;
      {addr, wdata, s_tx} = 24'h000000;
      err_total = 0;
      n_checks = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      get(`SCC_ADDR_CTRL, got);
      chk("control reset", 8'h00, got);
      chk("pins reset", 8'h0E, {4'h0, sclk_oe_n, ss_oe_n, ss_n, sclk});
      put(8'h10, 8'hFF);
      get(8'h10, got);
      chk("unmapped", 8'h00, got);
      put(`SCC_ADDR_STAT, 8'h08);
      put(`SCC_ADDR_MASK, 8'h80);
      for (int i = 0; i < 4; i++) begin
         xfer(rows[i][23:16], rows[i][15:8], rows[i][7:0], 1'b0);
      end
      xfer(8'hD0, 8'h5A, 8'h96, 1'b1);
      // master without select output: pin stays general purpose
      put(`SCC_ADDR_CTRL, 8'h50);
      put(`SCC_ADDR_DATA, 8'h3C);
      repeat (20) @(posedge clk);
      #1 chk("gpio select", 8'h01, {7'h00, ss_oe_n});
      wait_irq(1'b1);
      put(`SCC_ADDR_STAT, 8'h88);
      wait_irq(1'b0);
      // fault input: masked first, then raised and cleared
      put(`SCC_ADDR_STAT, 8'h00);
      put(`SCC_ADDR_CTRL, 8'hD0);
      put(`SCC_ADDR_MASK, 8'h00);
      @(posedge clk) ext_ss_n <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk("masked irq", 8'h00, {7'h00, irq});
      chk("fault select", 8'h01, {7'h00, ss_oe_n});
      put(`SCC_ADDR_MASK, 8'h10);
      wait_irq(1'b1);
      get(`SCC_ADDR_STAT, got);
      chk("fault flag", 8'h10, got);
      @(posedge clk) ext_ss_n <= 1'b1;
      put(`SCC_ADDR_STAT, 8'h10);
      wait_irq(1'b0);
      // slave: select is an input even with output enable set
      put(`SCC_ADDR_CTRL, 8'hC0);
      put(`SCC_ADDR_DATA, 8'h80);
      @(posedge clk) ext_ss_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("slave pins", 8'h05, {5'h00, miso, miso_oe_n, ss_oe_n});
      @(posedge clk) ext_ss_n <= 1'b1;
      put(`SCC_ADDR_CTRL, 8'h10);
      #1 chk("disabled", 8'h03, {6'h00, sclk_oe_n, mosi_oe_n});
      conclude();
   end
endmodule // scc_spi_control_config_bench
`default_nettype wire
